// ==== bench/fic_core_model.sv ====
`timescale 1ns/1ps
module fic_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [7:0] ack_dly,
  input wire logic [7:0] serve_len,
  output logic irq_ack,
  output logic irq_reti,
  output logic taken,
  output logic [7:0] taken_vec
);
  // ****************************************
  // Vector fetch and nested service timing
  // ****************************************
  logic [7:0] wait_ff;
  int stack_q[$];
  logic took;

  assign took = irq_ack && irq_req;

  always @(posedge mclk) begin
    taken <= 1'b0;
    irq_ack <= 1'b0;
    irq_reti <= 1'b0;
    if (rst) begin
      wait_ff <= 8'h00;
      taken_vec <= 8'h00;
      stack_q.delete();
    end else begin
      if (took) begin
        taken <= 1'b1;
        taken_vec <= irq_vector;
        stack_q.push_back(int'(serve_len));
      end else if (irq_req && !irq_ack) begin
        // Slow or prompt acceptance of a standing request
        if (wait_ff >= ack_dly) begin
          irq_ack <= 1'b1;
          wait_ff <= 8'h00;
        end else begin
          wait_ff <= wait_ff + 8'h01;
        end
      end
      // Only the innermost service runs; its return releases one level
      if (stack_q.size() > 0 && !took) begin
        if (stack_q[$] == 0) begin
          irq_reti <= 1'b1;
          void'(stack_q.pop_back());
        end else begin
          stack_q[$] = stack_q[$] - 1;
        end
      end
    end
  end
endmodule // fic_core_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import fic_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] pin_n = 4'hf;
  logic [5:0] set_pls = 6'h00;
  logic t0_set, t1_set, t2_set, t2x_set, rx_set, tx_set;
  logic updown = 1'b0;
  logic irq_ack, irq_reti, irq_req, taken, rd_seen;
  logic [7:0] irq_vector, taken_vec, exp_v;
  logic [1:0] irq_level, timer_run;
  logic [2:0] irq_source;
  logic [9:0] exp_n;
  logic [7:0] ack_dly = 8'h00;
  logic [7:0] serve_len = 8'hc8;
  // Vector notes carry {level, vector}
  logic [9:0] vec_q[$];
  logic [7:0] rd_q[$];
  int miscompares = 0;
  int checks_done = 0;
  int takes_n = 0;
  int i;
  logic [7:0] wd_tab[7] = '{8'h7f, 8'hff, 8'h00, 8'hdd, 8'h55, 8'h0f, 8'hff};
  logic [7:0] ex_tab[7] = '{8'h3f, 8'h3f, 8'h00, 8'hdd, 8'h55, 8'h0f, 8'h00};
  logic [7:0] hv_tab[6] = '{8'h0b, 8'h1b, 8'h2b, 8'h2b, 8'h23, 8'h23};
  logic [7:0] ha_tab[6] = '{8'h04, 8'h04, 8'h05, 8'h05, 8'h05, 8'h05};
  logic [7:0] hx_tab[6] = '{8'h00, 8'h00, 8'h04, 8'h08, 8'h01, 8'h02};

  always #2 mclk = ~mclk;

  fic_ctrl dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin_n(pin_n),
    .t0_ovf_set(t0_set), .t1_ovf_set(t1_set), .t2_ovf_set(t2_set),
    .t2_ext_set(t2x_set), .rx_done_set(rx_set), .tx_done_set(tx_set),
    .updown_reload_mode(updown), .irq_ack(irq_ack), .irq_reti(irq_reti), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .irq_source(irq_source),
    .timer_run(timer_run));

  assign {tx_set, rx_set, t2x_set, t2_set, t1_set, t0_set} = set_pls;

  fic_core_model core_u (.mclk(mclk), .rst(rst), .irq_req(irq_req), .irq_vector(irq_vector),
    .ack_dly(ack_dly), .serve_len(serve_len), .irq_ack(irq_ack), .irq_reti(irq_reti),
    .taken(taken), .taken_vec(taken_vec));

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge mclk) rd_seen <= reg_rd;

  // Results are matched against the oldest note left by the driver
  always @(negedge mclk) begin
    if (rd_seen === 1'b1) begin
      exp_v = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hee;
      check("read data", reg_rdata, exp_v);
    end
    if (taken === 1'b1) begin
      exp_n = (vec_q.size() > 0) ? vec_q.pop_front() : 10'h3ee;
      check("vector", taken_vec, exp_n[7:0]);
      check("source", {5'h00, irq_source}, (exp_n[7:0] - VEC_BASE) >> 3);
      check("level", {6'h00, irq_level}, {6'h00, exp_n[9:8]});
      takes_n++;
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic do_reset(input int cyc);
    check("pending vectors", 8'(vec_q.size()), 8'h00);
    vec_q.delete();
    @(posedge mclk);
    rst <= 1'b1;
    pin_n <= 4'hf;
    ack_dly <= 8'($urandom_range(3, 0));
    repeat (cyc) @(posedge mclk);
    rst <= 1'b0;
    takes_n = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic pulse(input int k);
    @(posedge mclk);
    set_pls[k] <= 1'b1;
    @(posedge mclk);
    set_pls[k] <= 1'b0;
  endtask

  task automatic wait_takes(input int n);
    for (int j = 0; j < 100 && takes_n < n; j++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    check("take count", 8'(takes_n), 8'(n));
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(37));
    wd_tab[2] = 8'($urandom);
    ex_tab[2] = wd_tab[2];
    do_reset(8);
    for (i = 0; i < 7; i++) rd(8'(i), 8'h00);
    for (i = 0; i < 7; i++) begin
      wr(8'(i), wd_tab[i]);
      rd(8'(i), ex_tab[i]);
    end
    check("timer run", {6'h00, timer_run}, 8'h03);
    repeat (10) @(posedge mclk);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      do_reset(2);
      vec_q.push_back({2'h0, VEC_BASE + 8'(8 * i)});
      wr(ADDR_TIMER_CTRL, 8'h05);
      wr(ADDR_TIMER_CTRL, 8'haf);
      wr(ADDR_SRC_FLAGS, 8'h0f);
      wr(ADDR_EXT_CTRL, 8'h11);
      wr(ADDR_EXT_CTRL, (i < 7) ? 8'h77 : 8'h73);
      wr(ADDR_INT_ENABLE, 8'h80 | (8'h3f & (8'hff << i)));
      wait_takes(1);
    end
    $display("test polling order done");
    do_reset(2);
    serve_len <= 8'h0c;
    vec_q.push_back({2'h2, 8'h1b});
    vec_q.push_back({2'h3, 8'h03});
    vec_q.push_back({2'h1, 8'h0b});
    wr(ADDR_PRIO_HIGH, 8'h09);
    wr(ADDR_PRIO_LOW, 8'h03);
    wr(ADDR_TIMER_CTRL, 8'ha1);
    wr(ADDR_INT_ENABLE, 8'h8b);
    wait_takes(1);
    wr(ADDR_TIMER_CTRL, 8'h23);
    wait_takes(3);
    serve_len <= 8'hc8;
    $display("test nesting done");
    for (i = 0; i < 6; i++) begin
      do_reset(2);
      wr(ADDR_INT_ENABLE, 8'hbf);
      vec_q.push_back({2'h0, hv_tab[i]});
      pulse(i);
      wait_takes(1);
      rd(ha_tab[i], hx_tab[i]);
    end
    do_reset(2);
    updown <= 1'b1;
    wr(ADDR_INT_ENABLE, 8'ha0);
    pulse(3);
    repeat (10) @(posedge mclk);
    rd(ADDR_SRC_FLAGS, 8'h08);
    vec_q.push_back({2'h0, 8'h2b});
    updown <= 1'b0;
    wait_takes(1);
    $display("test flag sources done");
    do_reset(2);
    wr(ADDR_INT_ENABLE, 8'h81);
    vec_q.push_back({2'h0, 8'h03});
    pin_n[0] <= 1'b0;
    wait_takes(1);
    rd(ADDR_TIMER_CTRL, 8'h02);
    pin_n[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(ADDR_TIMER_CTRL, 8'h00);
    do_reset(2);
    wr(ADDR_TIMER_CTRL, 8'h04);
    wr(ADDR_EXT_CTRL, 8'h11);
    wr(ADDR_EXT_CTRL, 8'h55);
    wr(ADDR_INT_ENABLE, 8'h80);
    vec_q.push_back({2'h0, 8'h3b});
    pin_n[3] <= 1'b0;
    wait_takes(1);
    rd(ADDR_EXT_CTRL, 8'h55);
    pin_n[2] <= 1'b0;
    pin_n[1] <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(ADDR_EXT_CTRL, 8'h57);
    rd(ADDR_TIMER_CTRL, 8'h0c);
    do_reset(2);
    $display("test pins done");
    tally_and_finish();
  end
endmodule // tb_top

// ==== design/fic_ctrl.sv ====
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module fic_ctrl
  import fic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] ext_irq_pin_n,
  input wire logic t0_ovf_set,
  input wire logic t1_ovf_set,
  input wire logic t2_ovf_set,
  input wire logic t2_ext_set,
  input wire logic rx_done_set,
  input wire logic tx_done_set,
  input wire logic updown_reload_mode,
  input wire logic irq_ack,
  input wire logic irq_reti,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [1:0] irq_level,
  output logic [2:0] irq_source,
  output logic [1:0] timer_run
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction

  function automatic logic flag_upd(input logic set, input logic wr, input logic val,
                                    input logic cur, input logic clr);
    return set | (wr ? val : (cur & ~clr));
  endfunction

  function automatic logic [1:0] top_level(input logic [3:0] v);
    return v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0] ie_ff;
  logic [7:0] ip_ff;
  logic [7:0] iph_ff;
  logic [7:0] xc_cfg_ff;
  logic [7:0] tc_cfg_ff;
  logic [3:0] ext_flag_ff;
  logic [1:0] tf_ff;
  logic [3:0] sf_ff;
  logic [3:0] inserv_ff;
  logic irq_req_ff;
  logic [7:0] irq_vector_ff;
  logic [1:0] irq_lvl_ff;
  logic [2:0] irq_src_ff;
  logic [7:0] rdata_ff;

  // ****************************************
  // Register decode
  // ****************************************
  wire wr_ie = reg_hit(reg_wr, reg_addr, ADDR_INT_ENABLE);
  wire wr_ip = reg_hit(reg_wr, reg_addr, ADDR_PRIO_LOW);
  wire wr_iph = reg_hit(reg_wr, reg_addr, ADDR_PRIO_HIGH);
  wire wr_xc = reg_hit(reg_wr, reg_addr, ADDR_EXT_CTRL);
  wire wr_tc = reg_hit(reg_wr, reg_addr, ADDR_TIMER_CTRL);
  wire wr_sf = reg_hit(reg_wr, reg_addr, ADDR_SRC_FLAGS);

  // ****************************************
  // External pins
  // ****************************************
  logic [3:0] ext_low;
  logic [3:0] ext_fall;

  fic_pin_sync u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_n(ext_irq_pin_n),
    .low_level(ext_low),
    .fall(ext_fall)
  );

  // ****************************************
  // Grant taken by the core
  // ****************************************
  wire ack_taken = irq_ack && irq_req_ff;
  wire [7:0] ack_hit = ack_taken ? (8'h01 << irq_src_ff) : 8'h00;

  // ****************************************
  // Request flags
  // ****************************************
  wire [3:0] ext_edge_sel = {xc_cfg_ff[XC_EXT3_EDGE], xc_cfg_ff[XC_EXT2_EDGE],
                             tc_cfg_ff[TC_EXT1_EDGE], tc_cfg_ff[TC_EXT0_EDGE]};
  wire [3:0] ext_wr_hit = {wr_xc, wr_xc, wr_tc, wr_tc};
  wire [3:0] ext_wr_val = {reg_wdata[XC_EXT3_FLAG], reg_wdata[XC_EXT2_FLAG],
                           reg_wdata[TC_EXT1_FLAG], reg_wdata[TC_EXT0_FLAG]};
  wire [3:0] ext_ack_clr = {ack_hit[SRC_EXT3], ack_hit[SRC_EXT2],
                            ack_hit[SRC_EXT1], ack_hit[SRC_EXT0]} & ext_edge_sel;
  wire [3:0] sf_set = {t2_ext_set, t2_ovf_set, tx_done_set, rx_done_set};
  logic [3:0] nxt_ext_flag;
  logic [3:0] nxt_sf;
  logic [1:0] nxt_tf;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_flag
      // Edge mode: set wins over clear; level mode: flag follows the pin
      assign nxt_ext_flag[i] = ext_edge_sel[i] ?
          flag_upd(ext_fall[i], ext_wr_hit[i], ext_wr_val[i], ext_flag_ff[i],
                   ext_ack_clr[i]) : ext_low[i];
      // Serial and timer 2 flags are never cleared by vectoring
      assign nxt_sf[i] = flag_upd(sf_set[i], wr_sf, reg_wdata[i], sf_ff[i], 1'b0);
    end
  endgenerate

  assign nxt_tf[0] = flag_upd(t0_ovf_set, wr_tc, reg_wdata[TC_T0_OVF], tf_ff[0],
                              ack_hit[SRC_T0]);
  assign nxt_tf[1] = flag_upd(t1_ovf_set, wr_tc, reg_wdata[TC_T1_OVF], tf_ff[1],
                              ack_hit[SRC_T1]);

  // ****************************************
  // Source requests, enables and levels
  // ****************************************
  wire t2_req = sf_ff[SF_T2_OVF] | (sf_ff[SF_T2_EXT] & ~updown_reload_mode);
  wire ser_req = sf_ff[SF_RX_DONE] | sf_ff[SF_TX_DONE];
  wire [7:0] src_req = {ext_flag_ff[3], ext_flag_ff[2], t2_req, ser_req,
                        tf_ff[1], ext_flag_ff[1], tf_ff[0], ext_flag_ff[0]};
  wire [7:0] src_en = {xc_cfg_ff[XC_EXT3_EN], xc_cfg_ff[XC_EXT2_EN],
                       ie_ff[IE_LOCAL_TOP:0]} & {8{ie_ff[IE_GLOBAL_BIT]}};
  wire [7:0] prio_lo_vec = {xc_cfg_ff[XC_EXT3_PRIO_LOW], xc_cfg_ff[XC_EXT2_PRIO_LOW],
                            ip_ff[IE_LOCAL_TOP:0]};
  wire [7:0] pend = src_req & src_en;

  logic arb_found;
  logic [2:0] arb_idx;
  logic [1:0] arb_lvl;

  // Level is {high, low}; higher level first, then polling order
  fic_prio_arb u_arb (
    .req(pend),
    .prio_high(iph_ff),
    .prio_low(prio_lo_vec),
    .found(arb_found),
    .idx(arb_idx),
    .lvl(arb_lvl)
  );

  // ****************************************
  // Nesting
  // ****************************************
  wire cur_valid = |inserv_ff;
  wire [1:0] cur_lvl = top_level(inserv_ff);
  wire preempt_ok = !cur_valid || (arb_lvl > cur_lvl);
  wire nxt_irq_req = arb_found && preempt_ok && !irq_ack;
  wire [3:0] reti_mask = (irq_reti && cur_valid) ? (4'h1 << cur_lvl) : 4'h0;
  wire [3:0] ack_mask = ack_taken ? (4'h1 << irq_lvl_ff) : 4'h0;
  wire [3:0] nxt_inserv = (inserv_ff & ~reti_mask) | ack_mask;
  wire [7:0] nxt_vector = VEC_BASE + {2'h0, arb_idx, 3'h0};

  // ****************************************
  // Read view
  // ****************************************
  wire [7:0] tc_view = tc_cfg_ff | {tf_ff[1], 1'b0, tf_ff[0], 1'b0,
                                    ext_flag_ff[1], 1'b0, ext_flag_ff[0], 1'b0};
  wire [7:0] xc_view = xc_cfg_ff | {2'h0, ext_flag_ff[3], 3'h0, ext_flag_ff[2], 1'b0};
  wire [7:0] rd_mux =
      reg_hit(reg_rd, reg_addr, ADDR_INT_ENABLE) ? ie_ff :
      reg_hit(reg_rd, reg_addr, ADDR_PRIO_LOW) ? ip_ff :
      reg_hit(reg_rd, reg_addr, ADDR_PRIO_HIGH) ? iph_ff :
      reg_hit(reg_rd, reg_addr, ADDR_EXT_CTRL) ? xc_view :
      reg_hit(reg_rd, reg_addr, ADDR_TIMER_CTRL) ? tc_view :
      reg_hit(reg_rd, reg_addr, ADDR_SRC_FLAGS) ? {4'h0, sf_ff} : RST_REG;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      ie_ff <= RST_REG;
      ip_ff <= RST_REG;
      iph_ff <= RST_REG;
      xc_cfg_ff <= RST_REG;
      tc_cfg_ff <= RST_REG;
    end else begin
      if (wr_ie) ie_ff <= reg_wdata & INT_ENABLE_MASK;
      if (wr_ip) ip_ff <= reg_wdata & PRIO_LOW_MASK;
      if (wr_iph) iph_ff <= reg_wdata;
      if (wr_xc) xc_cfg_ff <= reg_wdata & EXT_CTRL_CFG_MASK;
      if (wr_tc) tc_cfg_ff <= reg_wdata & TIMER_CTRL_CFG_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_flag_ff <= RST_NIBBLE;
      tf_ff <= RST_PAIR;
      sf_ff <= RST_NIBBLE;
      inserv_ff <= RST_NIBBLE;
      rdata_ff <= RST_REG;
    end else begin
      ext_flag_ff <= nxt_ext_flag;
      tf_ff <= nxt_tf;
      sf_ff <= nxt_sf;
      inserv_ff <= nxt_inserv;
      rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_req_ff <= 1'b0;
      irq_vector_ff <= VEC_BASE;
      irq_lvl_ff <= RST_PAIR;
      irq_src_ff <= SRC_EXT0;
    end else begin
      irq_req_ff <= nxt_irq_req;
      if (nxt_irq_req) begin
        irq_vector_ff <= nxt_vector;
        irq_lvl_ff <= arb_lvl;
        irq_src_ff <= arb_idx;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_req = irq_req_ff;
  assign irq_vector = irq_vector_ff;
  assign irq_level = irq_lvl_ff;
  assign irq_source = irq_src_ff;
  assign timer_run = {tc_cfg_ff[TC_T1_RUN], tc_cfg_ff[TC_T0_RUN]};

  // ****************************************
  // Assertions
  // ****************************************
  property p_global_block;
    @(posedge mclk) disable iff (rst)
      !ie_ff[IE_GLOBAL_BIT] |=> !irq_req_ff;
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("request raised while global enable clear");

  property p_vector_map;
    @(posedge mclk) disable iff (rst)
      irq_req_ff |-> (irq_vector_ff == {2'h0, irq_src_ff, 3'h3});
  endproperty
  a_vector_map: assert property (p_vector_map)
    else $error("vector does not match granted source");

  property p_no_lower_preempt;
    @(posedge mclk) disable iff (rst)
      ($rose(irq_req_ff) && $past(cur_valid)) |-> (irq_lvl_ff > $past(cur_lvl));
  endproperty
  a_no_lower_preempt: assert property (p_no_lower_preempt)
    else $error("request not above running level");

  sequence s_grant_ack;
    irq_req_ff && irq_ack && !irq_reti;
  endsequence

  property p_inserv_set;
    @(posedge mclk) disable iff (rst)
      s_grant_ack |=> inserv_ff[$past(irq_lvl_ff)] && !irq_req_ff;
  endproperty
  a_inserv_set: assert property (p_inserv_set)
    else $error("acknowledge did not mark level in service");

  property p_t0_autoclear;
    @(posedge mclk) disable iff (rst)
      (s_grant_ack and (irq_src_ff == SRC_T0) && !t0_ovf_set && !wr_tc) |=> !tf_ff[0];
  endproperty
  a_t0_autoclear: assert property (p_t0_autoclear)
    else $error("timer 0 flag not cleared on vectoring");

  property p_serial_kept;
    @(posedge mclk) disable iff (rst)
      (ack_taken && (irq_src_ff == SRC_SERIAL) && !wr_sf) |=>
        ((sf_ff[1:0] & $past(sf_ff[1:0])) == $past(sf_ff[1:0]));
  endproperty
  a_serial_kept: assert property (p_serial_kept)
    else $error("serial flags cleared by vectoring");

  property p_t2_kept;
    @(posedge mclk) disable iff (rst)
      (ack_taken && (irq_src_ff == SRC_T2) && !wr_sf) |=>
        ((sf_ff[3:2] & $past(sf_ff[3:2])) == $past(sf_ff[3:2]));
  endproperty
  a_t2_kept: assert property (p_t2_kept)
    else $error("timer 2 flags cleared by vectoring");

  property p_edge_sets;
    @(posedge mclk) disable iff (rst)
      (ext_edge_sel[2] && ext_fall[2]) |=> ext_flag_ff[2];
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge flag not set by falling edge");

  property p_level_follows;
    @(posedge mclk) disable iff (rst)
      !ext_edge_sel[3] |=> (ext_flag_ff[3] == $past(ext_low[3]));
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("level flag does not follow pin");

  property p_updown_mask;
    @(posedge mclk) disable iff (rst)
      (updown_reload_mode && !sf_ff[SF_T2_OVF]) |-> !src_req[SRC_T2];
  endproperty
  a_updown_mask: assert property (p_updown_mask)
    else $error("timer 2 external flag requested in up/down mode");

  property p_edge_autoclear;
    @(posedge mclk) disable iff (rst)
      (ack_taken && (irq_src_ff == SRC_EXT3) && ext_edge_sel[3] && !ext_fall[3] && !wr_xc)
        |=> !ext_flag_ff[3];
  endproperty
  a_edge_autoclear: assert property (p_edge_autoclear)
    else $error("edge flag not cleared on vectoring");

  property p_t1_autoclear;
    @(posedge mclk) disable iff (rst)
      (s_grant_ack and (irq_src_ff == SRC_T1) && !t1_ovf_set && !wr_tc) |=> !tf_ff[1];
  endproperty
  a_t1_autoclear: assert property (p_t1_autoclear)
    else $error("timer 1 flag not cleared on vectoring");

endmodule // fic_ctrl

// ==== design/fic_pin_sync.sv ====
`timescale 1ns/1ps
module fic_pin_sync
  import fic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] pin_n,
  output logic [3:0] low_level,
  output logic [3:0] fall
);

  // ****************************************
  // Two-stage synchroniser and falling edge
  // ****************************************
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [3:0] prev_ff;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      always_ff @(posedge mclk) begin
        if (rst) begin
          meta_ff[i] <= 1'b1;
          sync_ff[i] <= 1'b1;
          prev_ff[i] <= 1'b1;
        end else begin
          meta_ff[i] <= pin_n[i];
          sync_ff[i] <= meta_ff[i];
          prev_ff[i] <= sync_ff[i];
        end
      end
      assign low_level[i] = ~sync_ff[i];
      assign fall[i] = prev_ff[i] & ~sync_ff[i];
    end
  endgenerate

endmodule // fic_pin_sync

// ==== design/fic_pkg.sv ====
package fic_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'h01;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'h02;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h03;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_SRC_FLAGS = 8'h05;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [1:0] RST_PAIR = 2'h0;
  localparam logic [7:0] INT_ENABLE_MASK = 8'hBF;
  localparam logic [7:0] PRIO_LOW_MASK = 8'h3F;
  localparam logic [7:0] EXT_CTRL_CFG_MASK = 8'hDD;
  localparam logic [7:0] TIMER_CTRL_CFG_MASK = 8'h55;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int IE_GLOBAL_BIT = 7;
  localparam int IE_LOCAL_TOP = 5;
  localparam int XC_EXT3_PRIO_LOW = 7;
  localparam int XC_EXT3_EN = 6;
  localparam int XC_EXT3_FLAG = 5;
  localparam int XC_EXT3_EDGE = 4;
  localparam int XC_EXT2_PRIO_LOW = 3;
  localparam int XC_EXT2_EN = 2;
  localparam int XC_EXT2_FLAG = 1;
  localparam int XC_EXT2_EDGE = 0;
  localparam int TC_T1_OVF = 7;
  localparam int TC_T1_RUN = 6;
  localparam int TC_T0_OVF = 5;
  localparam int TC_T0_RUN = 4;
  localparam int TC_EXT1_FLAG = 3;
  localparam int TC_EXT1_EDGE = 2;
  localparam int TC_EXT0_FLAG = 1;
  localparam int TC_EXT0_EDGE = 0;
  localparam int SF_RX_DONE = 0;
  localparam int SF_TX_DONE = 1;
  localparam int SF_T2_OVF = 2;
  localparam int SF_T2_EXT = 3;

  // ****************************************
  // Sources in polling order and vectors
  // ****************************************
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_SERIAL = 3'h4;
  localparam logic [2:0] SRC_T2 = 3'h5;
  localparam logic [2:0] SRC_EXT2 = 3'h6;
  localparam logic [2:0] SRC_EXT3 = 3'h7;
  localparam logic [7:0] VEC_BASE = 8'h03;

endpackage

// ==== design/fic_prio_arb.sv ====
`timescale 1ns/1ps
module fic_prio_arb
  import fic_pkg::*;
(
  input wire logic [7:0] req,
  input wire logic [7:0] prio_high,
  input wire logic [7:0] prio_low,
  output logic found,
  output logic [2:0] idx,
  output logic [1:0] lvl
);

  // ****************************************
  // Per-level masks, then fixed polling order
  // ****************************************
  function automatic logic [2:0] first_idx(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  logic [7:0] lvl_mask [4];
  logic [3:0] lvl_any;

  genvar l;
  generate
    for (l = 0; l < 4; l++) begin : g_lvl
      localparam logic [1:0] LV = 2'(l);
      assign lvl_mask[l] = req & (LV[1] ? prio_high : ~prio_high)
                               & (LV[0] ? prio_low : ~prio_low);
      assign lvl_any[l] = |lvl_mask[l];
    end
  endgenerate

  assign lvl = lvl_any[3] ? 2'h3 : lvl_any[2] ? 2'h2 : lvl_any[1] ? 2'h1 : 2'h0;
  assign found = |lvl_any;
  assign idx = first_idx(lvl_mask[lvl]);

endmodule // fic_prio_arb
